//--- hw/sftu_top.sv
// filters, trigger detector, capture control and ahb-lite registers
//
// Register access over AHB-Lite and the register offsets were left to the implementer.
`default_nettype none
module sftu_top (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic sample_valid_i,
	input wire logic [15:0] sample_a_i,
	input wire logic [15:0] sample_b_i,
	input wire logic [15:0] sample_c_i,
	input wire logic [15:0] sample_d_i,
	output logic [15:0] filt_a_o,
	output logic [15:0] filt_b_o,
	output logic [15:0] filt_c_o,
	output logic [15:0] filt_d_o,
	output logic filt_valid_o,
	output logic cap_valid_o,
	output logic capturing_o,
	output logic trig_o,
	output logic irq_o
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic wr_pend_reg, wr_pend_next, rd_wait_reg, rd_wait_next;
	logic [7:0] dph_addr_reg, dph_addr_next;
	logic [31:0] hrdata_reg, hrdata_next;
	logic [sftu_pkg::CTRL_W-1:0] ctrl_reg, ctrl_next;
	logic rearm_reg, rearm_next;
	logic [15:0] thresh_reg, thresh_next, hyst_reg, hyst_next, caplen_reg, caplen_next;
	logic [31:0] auto_reg, auto_next;
	logic [sftu_pkg::IRQ_W-1:0] istat_reg, istat_next, imask_reg, imask_next, events;
	localparam int ACCX = sftu_pkg::ACCW + 1;
	logic [31:0] fcfg_reg [sftu_pkg::NCH], fcfg_next [sftu_pkg::NCH];
	logic [15:0] samp_in [sftu_pkg::NCH];
	logic signed [sftu_pkg::ACCW-1:0] acc_reg [sftu_pkg::NCH], acc_next [sftu_pkg::NCH];
	logic [15:0] filt_reg [sftu_pkg::NCH], filt_next [sftu_pkg::NCH];
	logic filt_valid_reg;
	sftu_pkg::sftu_state_t state_reg, state_next;
	logic [31:0] wait_cnt_reg, wait_cnt_next;
	logic [15:0] samp_cnt_reg, samp_cnt_next;
	logic signed [15:0] prev_reg, prev_next, cur;
	logic have_prev_reg, have_prev_next, arm_up_reg, arm_up_next, arm_dn_reg, arm_dn_next;
	logic trig_reg, trig_next, fire, up_x, dn_x, rise_f, fall_f;
	logic signed [17:0] th_w, cur_w, prev_w, lo_w, hi_w;
	sftu_pkg::sftu_mode_t mode;
	sftu_pkg::sftu_dir_t dir;
	logic run, hyst_en;
	wire logic acc = hsel_i && htrans_i[1] && hready_i;

	assign samp_in[0] = sample_a_i;
	assign samp_in[1] = sample_b_i;
	assign samp_in[2] = sample_c_i;
	assign samp_in[3] = sample_d_i;
	assign run = ctrl_reg[sftu_pkg::CTRL_RUN];
	assign hyst_en = ctrl_reg[sftu_pkg::CTRL_HYST];
	assign mode = sftu_pkg::sftu_mode_t'(ctrl_reg[sftu_pkg::CTRL_MODE +: 2]);
	assign dir = sftu_pkg::sftu_dir_t'(ctrl_reg[sftu_pkg::CTRL_DIR +: 2]);

	// ----------------------------------------
	// cutoff to filter shift
	// ----------------------------------------
	// cutoff from value and unit
	// picks the largest k with 2*pi*fc*2^k <= fs; coarse octave steps keep it multiplier-free
	function automatic logic [sftu_pkg::SHW-1:0] cut_shift(input logic [31:0] cfg);
		logic [63:0] hz;
		logic [63:0] scale;
		logic [sftu_pkg::SHW-1:0] k;
		case (sftu_pkg::sftu_unit_t'(cfg[sftu_pkg::FILTER_UNIT +: 2]))
			sftu_pkg::UNIT_KHZ: scale = sftu_pkg::SCALE_KHZ;
			sftu_pkg::UNIT_MHZ: scale = sftu_pkg::SCALE_MHZ;
			default: scale = sftu_pkg::SCALE_HZ;
		endcase
		hz = 64'(cfg[sftu_pkg::FILTER_VAL +: 16]) * scale * sftu_pkg::TWO_PI_APPROX;
		k = '0;
		for (int i = 1; i <= sftu_pkg::MAX_SHIFT; i++)
		begin
			if ((hz << i) <= sftu_pkg::SAMPLE_RATE_HZ)
				k = sftu_pkg::SHW'(i);
		end
		return k;
	endfunction

	function automatic logic [31:0] rd_mux(input logic [7:0] a);
		logic [31:0] d;
		d = '0;
		if (a[7:4] == sftu_pkg::A_FILTER_PAGE)
			d = fcfg_reg[a[3:2]];
		else
		begin
			case (a)
				sftu_pkg::A_CTRL: d = 32'(ctrl_reg);
				sftu_pkg::A_THRESH: d = 32'(thresh_reg);
				sftu_pkg::A_HYST: d = 32'(hyst_reg);
				sftu_pkg::A_AUTO: d = auto_reg;
				sftu_pkg::A_CAPLEN: d = 32'(caplen_reg);
				sftu_pkg::A_STATUS: d = 32'({arm_dn_reg, arm_up_reg, state_reg});
				sftu_pkg::A_ISTAT: d = 32'(istat_reg);
				sftu_pkg::A_IMASK: d = 32'(imask_reg);
				default: d = '0;
			endcase
		end
		return d;
	endfunction

	// ----------------------------------------
	// bus slave and registers
	// ----------------------------------------
	// reads take one wait state so that hrdata comes from a flip-flop
	always_comb
	begin
		wr_pend_next = acc && hwrite_i;
		rd_wait_next = acc && !hwrite_i;
		dph_addr_next = acc ? haddr_i[7:0] : dph_addr_reg;
		hrdata_next = rd_wait_reg ? rd_mux(dph_addr_reg) : hrdata_reg;
		ctrl_next = ctrl_reg;
		rearm_next = 1'b0;
		thresh_next = thresh_reg;
		hyst_next = hyst_reg;
		auto_next = auto_reg;
		caplen_next = caplen_reg;
		imask_next = imask_reg;
		fcfg_next = fcfg_reg;
		istat_next = istat_reg;
		if (wr_pend_reg)
		begin
			if (dph_addr_reg[7:4] == sftu_pkg::A_FILTER_PAGE)
				fcfg_next[dph_addr_reg[3:2]] = hwdata_i & sftu_pkg::FILTER_MASK;
			case (dph_addr_reg)
				sftu_pkg::A_CTRL:
				begin
					ctrl_next = hwdata_i[sftu_pkg::CTRL_W-1:0];
					rearm_next = hwdata_i[sftu_pkg::CTRL_REARM];
				end
				sftu_pkg::A_THRESH: thresh_next = hwdata_i[15:0];
				sftu_pkg::A_HYST: hyst_next = hwdata_i[15:0];
				sftu_pkg::A_AUTO: auto_next = hwdata_i;
				sftu_pkg::A_CAPLEN: caplen_next = hwdata_i[15:0];
				sftu_pkg::A_ISTAT: istat_next = istat_reg & ~hwdata_i[sftu_pkg::IRQ_W-1:0];
				sftu_pkg::A_IMASK: imask_next = hwdata_i[sftu_pkg::IRQ_W-1:0];
				default: ;
			endcase
		end
		// a new event wins over a write-one clear in the same cycle
		istat_next = istat_next | events;
	end

	always_ff @(posedge clock_i)
	begin
		if (!nrst_i)
		begin
			wr_pend_reg <= 1'b0;
			rd_wait_reg <= 1'b0;
			dph_addr_reg <= '0;
			hrdata_reg <= '0;
			ctrl_reg <= '0;
			rearm_reg <= 1'b0;
			thresh_reg <= '0;
			hyst_reg <= '0;
			auto_reg <= sftu_pkg::AUTO_RST;
			caplen_reg <= sftu_pkg::CAPLEN_RST;
			istat_reg <= '0;
			imask_reg <= '0;
			fcfg_reg <= '{default: '0};
		end
		else
		begin
			wr_pend_reg <= wr_pend_next;
			rd_wait_reg <= rd_wait_next;
			dph_addr_reg <= dph_addr_next;
			hrdata_reg <= hrdata_next;
			ctrl_reg <= ctrl_next;
			rearm_reg <= rearm_next;
			thresh_reg <= thresh_next;
			hyst_reg <= hyst_next;
			auto_reg <= auto_next;
			caplen_reg <= caplen_next;
			istat_reg <= istat_next;
			imask_reg <= imask_next;
			fcfg_reg <= fcfg_next;
		end
	end

	assign hrdata_o = hrdata_reg;
	assign hreadyout_o = !rd_wait_reg;
	assign hresp_o = 1'b0;
	assign irq_o = |(istat_reg & imask_reg);

	// ----------------------------------------
	// lowpass filters
	// ----------------------------------------
	// per-channel filter and bypass
	always_comb
	begin
		acc_next = acc_reg;
		filt_next = filt_reg;
		for (int c = 0; c < sftu_pkg::NCH; c++)
		begin
			if (sample_valid_i)
			begin
				if (fcfg_reg[c][sftu_pkg::FILTER_EN])
				begin
					// one guard bit keeps a full-scale step from wrapping the difference
					acc_next[c] = acc_reg[c] + sftu_pkg::ACCW'(
						($signed({samp_in[c][sftu_pkg::DW-1], samp_in[c],
						{sftu_pkg::FRAC{1'b0}}}) - ACCX'(acc_reg[c]))
						>>> cut_shift(fcfg_reg[c]));
					filt_next[c] = acc_next[c][sftu_pkg::ACCW-1:sftu_pkg::FRAC];
				end
				else
				begin
					// bypass keeps the accumulator tracking, so enabling causes no step
					acc_next[c] = $signed({samp_in[c], {sftu_pkg::FRAC{1'b0}}});
					filt_next[c] = samp_in[c];
				end
			end
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (!nrst_i)
		begin
			acc_reg <= '{default: '0};
			filt_reg <= '{default: '0};
			filt_valid_reg <= 1'b0;
		end
		else
		begin
			acc_reg <= acc_next;
			filt_reg <= filt_next;
			filt_valid_reg <= sample_valid_i;
		end
	end

	assign filt_a_o = filt_reg[0];
	assign filt_b_o = filt_reg[1];
	assign filt_c_o = filt_reg[2];
	assign filt_d_o = filt_reg[3];
	assign filt_valid_o = filt_valid_reg;

	// ----------------------------------------
	// trigger detector and capture control
	// ----------------------------------------
	always_comb
	begin
		cur = $signed(filt_reg[ctrl_reg[sftu_pkg::CTRL_CH +: 2]]);
		cur_w = 18'(cur);
		prev_w = 18'(prev_reg);
		th_w = 18'($signed(thresh_reg));
		lo_w = th_w - $signed({2'b00, hyst_reg});
		hi_w = th_w + $signed({2'b00, hyst_reg});
		up_x = filt_valid_reg && have_prev_reg && prev_w < th_w && cur_w >= th_w;
		dn_x = filt_valid_reg && have_prev_reg && prev_w > th_w && cur_w <= th_w;
		rise_f = hyst_en ? (filt_valid_reg && arm_up_reg && cur_w >= th_w) : up_x;
		fall_f = hyst_en ? (filt_valid_reg && arm_dn_reg && cur_w <= th_w) : dn_x;
		case (dir)
			sftu_pkg::DIR_FALL: fire = fall_f;
			sftu_pkg::DIR_EITHER: fire = rise_f || fall_f;
			default: fire = rise_f;
		endcase
		prev_next = filt_valid_reg ? cur : prev_reg;
		have_prev_next = have_prev_reg || filt_valid_reg;
		arm_up_next = (arm_up_reg || (filt_valid_reg && cur_w < lo_w)) && !rise_f;
		arm_dn_next = (arm_dn_reg || (filt_valid_reg && cur_w > hi_w)) && !fall_f;
		state_next = state_reg;
		wait_cnt_next = wait_cnt_reg;
		samp_cnt_next = samp_cnt_reg;
		trig_next = 1'b0;
		events = '0;
		case (state_reg)
			sftu_pkg::ST_STOP:
			begin
				wait_cnt_next = '0;
				if (run)
					state_next = sftu_pkg::ST_WAIT;
			end
			sftu_pkg::ST_WAIT:
			begin
				samp_cnt_next = '0;
				wait_cnt_next = wait_cnt_reg + 32'h1;
				if (!run)
					state_next = sftu_pkg::ST_STOP;
				else if (mode == sftu_pkg::MODE_NONE)
					state_next = sftu_pkg::ST_CAPT;
				else if (fire)
				begin
					state_next = sftu_pkg::ST_CAPT;
					trig_next = 1'b1;
					events[sftu_pkg::IRQ_TRIG] = 1'b1;
				end
				else if (mode == sftu_pkg::MODE_AUTO && wait_cnt_reg >= auto_reg)
				begin
					state_next = sftu_pkg::ST_CAPT;
					events[sftu_pkg::IRQ_AUTO] = 1'b1;
				end
			end
			sftu_pkg::ST_CAPT:
			begin
				wait_cnt_next = '0;
				if (filt_valid_reg)
					samp_cnt_next = samp_cnt_reg + 16'h1;
				if (!run)
					state_next = sftu_pkg::ST_STOP;
				else if (filt_valid_reg && samp_cnt_next >= caplen_reg)
				begin
					events[sftu_pkg::IRQ_DONE] = 1'b1;
					state_next = (mode == sftu_pkg::MODE_SINGLE) ? sftu_pkg::ST_HALT :
						sftu_pkg::ST_WAIT;
				end
			end
			sftu_pkg::ST_HALT:
			begin
				if (!run)
					state_next = sftu_pkg::ST_STOP;
				else if (rearm_reg)
					state_next = sftu_pkg::ST_WAIT;
			end
			default: state_next = sftu_pkg::ST_STOP;
		endcase
	end

	always_ff @(posedge clock_i)
	begin
		if (!nrst_i)
		begin
			state_reg <= sftu_pkg::ST_STOP;
			wait_cnt_reg <= '0;
			samp_cnt_reg <= '0;
			prev_reg <= '0;
			have_prev_reg <= 1'b0;
			arm_up_reg <= 1'b0;
			arm_dn_reg <= 1'b0;
			trig_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			wait_cnt_reg <= wait_cnt_next;
			samp_cnt_reg <= samp_cnt_next;
			prev_reg <= prev_next;
			have_prev_reg <= have_prev_next;
			arm_up_reg <= arm_up_next;
			arm_dn_reg <= arm_dn_next;
			trig_reg <= trig_next;
		end
	end

	assign capturing_o = (state_reg == sftu_pkg::ST_CAPT);
	assign cap_valid_o = capturing_o && filt_valid_reg;
	assign trig_o = trig_reg;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!nrst_i);

	property p_bypass;
		sample_valid_i && !fcfg_reg[0][sftu_pkg::FILTER_EN] |=> filt_reg[0] == $past(sample_a_i);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass output wrong");
	property p_none;
		state_reg == sftu_pkg::ST_WAIT && run && mode == sftu_pkg::MODE_NONE |=> capturing_o;
	endproperty
	a_none: assert property (p_none) else $error("none mode did not capture");
	property p_auto;
		state_reg == sftu_pkg::ST_WAIT && run && mode == sftu_pkg::MODE_AUTO
			&& wait_cnt_reg >= auto_reg |=> capturing_o;
	endproperty
	a_auto: assert property (p_auto) else $error("auto timeout missed");
	property p_repeat;
		state_reg == sftu_pkg::ST_WAIT && mode == sftu_pkg::MODE_REPEAT && !fire |=> !capturing_o;
	endproperty
	a_repeat: assert property (p_repeat) else $error("repeat captured untriggered");
	property p_single;
		state_reg == sftu_pkg::ST_HALT && run && !rearm_reg |=> state_reg == sftu_pkg::ST_HALT;
	endproperty
	a_single: assert property (p_single) else $error("single mode left halt");
	property p_trig;
		state_reg == sftu_pkg::ST_WAIT && run && mode != sftu_pkg::MODE_NONE && fire
			|=> trig_o && capturing_o ##1 !trig_o;
	endproperty
	a_trig: assert property (p_trig) else $error("trigger pulse wrong");
	property p_rise;
		fire && dir == sftu_pkg::DIR_RISE && !hyst_en |-> prev_w < th_w && cur_w >= th_w;
	endproperty
	a_rise: assert property (p_rise) else $error("rise fired wrongly");
	property p_fall;
		fire && dir == sftu_pkg::DIR_FALL && !hyst_en |-> prev_w > th_w && cur_w <= th_w;
	endproperty
	a_fall: assert property (p_fall) else $error("fall fired wrongly");
	property p_hyst;
		fire && hyst_en && dir == sftu_pkg::DIR_RISE |-> arm_up_reg ##1 !arm_up_reg;
	endproperty
	a_hyst: assert property (p_hyst) else $error("hysteresis not armed");
endmodule
`default_nettype wire

//--- hw/sftu_pkg.sv
// constants, register map and types of the scope filter and trigger unit
`default_nettype none
package sftu_pkg;
	// ----------------------------------------
	// data path
	// ----------------------------------------
	localparam int DW = 16;
	localparam int NCH = 4;
	localparam int FRAC = 8;
	localparam int ACCW = DW + FRAC;
	localparam int SHW = 4;
	localparam int MAX_SHIFT = 15;
	// sample rate seen by the filters, one sample set per cycle at most
	localparam logic [63:0] SAMPLE_RATE_HZ = 64'd20_000_000;
	// two pi rounded to a whole factor, close enough for a one-pole cutoff
	localparam logic [63:0] TWO_PI_APPROX = 64'h6;
	localparam logic [63:0] SCALE_HZ = 64'd1;
	localparam logic [63:0] SCALE_KHZ = 64'd1_000;
	localparam logic [63:0] SCALE_MHZ = 64'd1_000_000;

	// ----------------------------------------
	// register map, byte addresses
	// ----------------------------------------
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_THRESH = 8'h04;
	localparam logic [7:0] A_HYST = 8'h08;
	localparam logic [7:0] A_AUTO = 8'h0c;
	localparam logic [7:0] A_CAPLEN = 8'h10;
	localparam logic [7:0] A_STATUS = 8'h14;
	localparam logic [7:0] A_ISTAT = 8'h18;
	localparam logic [7:0] A_IMASK = 8'h1c;
	// filter settings of channels 0..3 at 0x20, 0x24, 0x28, 0x2c
	localparam logic [3:0] A_FILTER_PAGE = 4'h2;

	// ----------------------------------------
	// fields
	// ----------------------------------------
	localparam int CTRL_RUN = 0;
	localparam int CTRL_MODE = 1;
	localparam int CTRL_DIR = 3;
	localparam int CTRL_HYST = 5;
	localparam int CTRL_CH = 6;
	localparam int CTRL_REARM = 8;
	localparam int CTRL_W = 8;
	localparam int IRQ_TRIG = 0;
	localparam int IRQ_DONE = 1;
	localparam int IRQ_AUTO = 2;
	localparam int IRQ_W = 3;
	localparam int FILTER_EN = 0;
	localparam int FILTER_UNIT = 4;
	localparam int FILTER_VAL = 16;
	localparam logic [31:0] FILTER_MASK = 32'hffff_0031;
	localparam logic [31:0] AUTO_RST = 32'h0000_4e20;
	localparam logic [15:0] CAPLEN_RST = 16'h0400;

	typedef enum logic [1:0] {MODE_NONE = 2'h0, MODE_AUTO = 2'h1, MODE_REPEAT = 2'h2,
		MODE_SINGLE = 2'h3} sftu_mode_t;
	typedef enum logic [1:0] {DIR_RISE = 2'h0, DIR_FALL = 2'h1, DIR_EITHER = 2'h2,
		DIR_RSVD = 2'h3} sftu_dir_t;
	typedef enum logic [1:0] {UNIT_HZ = 2'h0, UNIT_KHZ = 2'h1, UNIT_MHZ = 2'h2,
		UNIT_RSVD = 2'h3} sftu_unit_t;
	typedef enum logic [3:0] {ST_STOP = 4'h1, ST_WAIT = 4'h2, ST_CAPT = 4'h4,
		ST_HALT = 4'h8} sftu_state_t;
endpackage
`default_nettype wire

//--- verification/sftu_afe_model.sv
// behavioural analog front end feeding four channel samples
`default_nettype none
module sftu_afe_model (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic [1:0] chan_i,
	input wire logic [15:0] lvl_i,
	output logic valid_o,
	output logic [15:0] a_o,
	output logic [15:0] b_o,
	output logic [15:0] c_o,
	output logic [15:0] d_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic tick_reg;

	// idle channels sit at a fixed negative level that never crosses a positive threshold
	function automatic logic [15:0] pick(input logic [1:0] ch);
		pick = (chan_i == ch) ? lvl_i : 16'hf000;
	endfunction

	// ----------------------------------------
	// sample pacing
	// ----------------------------------------
	// one set every other cycle; between sets the lines carry junk, so stale data never passes
	always_ff @(posedge clock_i)
	begin
		if (!nrst_i)
		begin
			tick_reg <= 1'b0;
			valid_o <= 1'b0;
			a_o <= 16'h0000;
			b_o <= 16'h0000;
			c_o <= 16'h0000;
			d_o <= 16'h0000;
		end
		else
		begin
			tick_reg <= ~tick_reg;
			valid_o <= tick_reg;
			a_o <= tick_reg ? pick(2'h0) : ~a_o;
			b_o <= tick_reg ? pick(2'h1) : ~b_o;
			c_o <= tick_reg ? pick(2'h2) : ~c_o;
			d_o <= tick_reg ? pick(2'h3) : ~d_o;
		end
	end
endmodule
`default_nettype wire

//--- verification/test_scope_filter_trigger_unit.sv
// self-checking bench of the scope filter and trigger unit
`default_nettype none
module test_scope_filter_trigger_unit;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_i = 1'b0;
	logic nrst_i = 1'b0;
	logic hsel, hwrite, hreadyout, hresp, svalid, fvalid, cap_valid, capturing, trig, irq;
	logic [1:0] htrans, mchan;
	logic [31:0] haddr, hwdata, hrdata;
	logic [15:0] lvl, sa, sb, sc, sd, fa, fb, fc, fd;
	int fail_count = 0;
	int n_checks = 0;

	always #25 clock_i = ~clock_i;

	sftu_top dut (.clock_i(clock_i), .nrst_i(nrst_i), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
		.hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
		.sample_valid_i(svalid), .sample_a_i(sa), .sample_b_i(sb), .sample_c_i(sc),
		.sample_d_i(sd), .filt_a_o(fa), .filt_b_o(fb), .filt_c_o(fc), .filt_d_o(fd),
		.filt_valid_o(fvalid), .cap_valid_o(cap_valid), .capturing_o(capturing),
		.trig_o(trig), .irq_o(irq));

	sftu_afe_model afe (.clock_i(clock_i), .nrst_i(nrst_i), .chan_i(mchan), .lvl_i(lvl),
		.valid_o(svalid), .a_o(sa), .b_o(sb), .c_o(sc), .d_o(sd));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// entered right after a rising edge; holds each phase until hready is sampled high
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h000000, a};
		hwrite <= w;
		do @(posedge clock_i); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clock_i); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'b1, a, d, x);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] x);
		ahb(1'b0, a, 32'h0, x);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clock_i);
	endtask

	task automatic watch(input int n, output int tn, output int cn);
		tn = 0;
		cn = 0;
		repeat (n)
		begin
			@(posedge clock_i);
			if (trig === 1'b1)
				tn++;
			if (cap_valid === 1'b1)
				cn++;
		end
	endtask

	function automatic logic [31:0] ctrl(input sftu_pkg::sftu_mode_t m,
		input sftu_pkg::sftu_dir_t d, input logic h, input logic [1:0] c);
		ctrl = 32'h1 | (32'(m) << sftu_pkg::CTRL_MODE) | (32'(d) << sftu_pkg::CTRL_DIR)
			| (32'(h) << sftu_pkg::CTRL_HYST) | (32'(c) << sftu_pkg::CTRL_CH);
	endfunction

	// stop, park the level, clear events and restart with a new control word
	task automatic arm(input logic [31:0] c, input logic [15:0] v);
		wr(sftu_pkg::A_CTRL, 32'h0);
		lvl <= v;
		wr(sftu_pkg::A_ISTAT, 32'h7);
		wr(sftu_pkg::A_CTRL, c);
		idle(6);
	endtask

	// a trigger must bring exactly one capture of four samples (capture length is 4)
	task automatic step(input string n, input logic [15:0] v, input int et);
		int tn, cn;
		lvl <= v;
		watch(24, tn, cn);
		chk({n, " trig"}, et, tn);
		chk({n, " capt"}, 4 * et, cn);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		logic [31:0] x;
		rd(sftu_pkg::A_CTRL, x);
		chk("ctrl reset", 32'h0, x);
		rd(sftu_pkg::A_AUTO, x);
		chk("auto reset", sftu_pkg::AUTO_RST, x);
		rd(sftu_pkg::A_CAPLEN, x);
		chk("caplen reset", {16'h0000, sftu_pkg::CAPLEN_RST}, x);
		rd(8'hf0, x);
		chk("unmapped read", 32'h0, x);
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask

	task automatic t_filter();
		logic [31:0] x;
		int nv;
		mchan <= 2'h1;
		lvl <= 16'h0000;
		// channel b must settle at zero in bypass before its slow filter is switched on
		idle(4);
		wr({sftu_pkg::A_FILTER_PAGE, 4'h4}, 32'h0001_0001);
		wr({sftu_pkg::A_FILTER_PAGE, 4'h8}, 32'h000a_0021);
		wr({sftu_pkg::A_FILTER_PAGE, 4'hc}, 32'h2710_0011);
		idle(4);
		lvl <= 16'h4000;
		nv = 0;
		repeat (6)
		begin
			@(posedge clock_i);
			if (fvalid === 1'b1)
				nv++;
		end
		chk("filt_valid pulses", 32'h3, nv);
		chk("filt_b slow", 32'h1, {31'h0, !fb[15] && fb < 16'h4000});
		chk("filt_a bypass", 32'h0000_f000, {16'h0, fa});
		mchan <= 2'h2;
		idle(6);
		chk("filt_c fast", 32'h0000_4000, {16'h0, fc});
		mchan <= 2'h3;
		idle(6);
		chk("filt_d khz", 32'h0000_4000, {16'h0, fd});
		rd({sftu_pkg::A_FILTER_PAGE, 4'h4}, x);
		chk("filter1 readback", 32'h0001_0001, x);
		// the trigger scenarios watch channels a and b unfiltered
		wr({sftu_pkg::A_FILTER_PAGE, 4'h4}, 32'h0);
		mchan <= 2'h0;
	endtask

	task automatic t_edge();
		for (int d = 0; d < 3; d++)
		begin
			arm(ctrl(sftu_pkg::MODE_REPEAT, sftu_pkg::sftu_dir_t'(d), 1'b0, 2'h0), 16'h0);
			step("quiet", 16'h0000, 0);
			step("up", 16'h0200, int'(d != 1));
			step("down", 16'h0000, int'(d != 0));
		end
	endtask

	task automatic t_irq();
		logic [31:0] x;
		idle(1);
		chk("irq set", 32'h1, {31'h0, irq});
		wr(sftu_pkg::A_IMASK, 32'h0);
		idle(1);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(sftu_pkg::A_IMASK, 32'h1);
		wr(sftu_pkg::A_ISTAT, 32'h1);
		idle(1);
		chk("irq cleared", 32'h0, {31'h0, irq});
		rd(sftu_pkg::A_ISTAT, x);
		chk("istat trig", 32'h0, x & 32'h1);
	endtask

	task automatic t_chan();
		arm(ctrl(sftu_pkg::MODE_REPEAT, sftu_pkg::DIR_RISE, 1'b0, 2'h1), 16'h0000);
		step("other chan", 16'h0200, 0);
		step("other back", 16'h0000, 0);
		mchan <= 2'h1;
		step("sel quiet", 16'h0000, 0);
		step("sel chan", 16'h0200, 1);
		mchan <= 2'h0;
	endtask

	// threshold 0x100, hysteresis 0x40: rise arms below 0xc0, fall arms above 0x140
	task automatic t_hyst();
		logic [15:0] far, near, over;
		for (int d = 0; d < 2; d++)
		begin
			far = d ? 16'h0200 : 16'h0000;
			near = d ? 16'h0130 : 16'h00d0;
			over = d ? 16'h0000 : 16'h0200;
			arm(ctrl(sftu_pkg::MODE_REPEAT, sftu_pkg::sftu_dir_t'(d), 1'b1, 2'h0), far);
			step("hyst first", over, 1);
			step("hyst near", near, 0);
			step("hyst unarmed", over, 0);
			step("hyst rearm", far, 0);
			step("hyst fire", over, 1);
		end
	endtask

	task automatic t_auto();
		logic [31:0] x;
		int tn, cn;
		wr(sftu_pkg::A_AUTO, 32'h200);
		arm(ctrl(sftu_pkg::MODE_AUTO, sftu_pkg::DIR_RISE, 1'b0, 2'h0), 16'h0000);
		watch(40, tn, cn);
		chk("auto waits", 32'h0, cn);
		wr(sftu_pkg::A_AUTO, 32'h8);
		watch(40, tn, cn);
		chk("auto trig", 32'h0, tn);
		chk("auto forced", 32'h1, int'(cn > 0));
		rd(sftu_pkg::A_ISTAT, x);
		chk("istat auto", 32'h4, x & 32'h4);
	endtask

	task automatic t_none();
		int tn, cn;
		arm(ctrl(sftu_pkg::MODE_NONE, sftu_pkg::DIR_RISE, 1'b0, 2'h0), 16'h0000);
		watch(20, tn, cn);
		chk("none capt", 32'h1, int'(cn >= 5));
		chk("none trig", 32'h0, tn);
	endtask

	task automatic t_single();
		logic [31:0] c, x;
		c = ctrl(sftu_pkg::MODE_SINGLE, sftu_pkg::DIR_RISE, 1'b0, 2'h0);
		arm(c, 16'h0000);
		step("single fire", 16'h0200, 1);
		rd(sftu_pkg::A_STATUS, x);
		chk("halted", 32'h8, x & 32'hf);
		chk("halt capturing", 32'h0, {31'h0, capturing});
		step("single low", 16'h0000, 0);
		step("single high", 16'h0200, 0);
		wr(sftu_pkg::A_CTRL, c | 32'h100);
		idle(4);
		rd(sftu_pkg::A_STATUS, x);
		chk("rearmed", 32'h2, x & 32'hf);
		step("rearmed low", 16'h0000, 0);
		step("rearmed fire", 16'h0200, 1);
	endtask

	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial
	begin
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		mchan = 2'h0;
		lvl = 16'h0000;
		repeat (10) @(posedge clock_i);
		nrst_i <= 1'b1;
		idle(2);
		t_reset();
		t_filter();
		wr(sftu_pkg::A_THRESH, 32'h100);
		wr(sftu_pkg::A_HYST, 32'h40);
		wr(sftu_pkg::A_CAPLEN, 32'h4);
		wr(sftu_pkg::A_IMASK, 32'h1);
		t_edge();
		t_irq();
		t_chan();
		t_hyst();
		t_auto();
		t_none();
		t_single();
		give_verdict();
	end

	// the whole run needs about a thousand cycles; this allows some forty thousand
	initial
	begin
		#2_000_000;
		fail_count++;
		$display("[ERR] watchdog expected finish seen timeout");
		give_verdict();
	end
endmodule
`default_nettype wire
